// *** hw/rsu_regs.sv ***
// Purpose: Boot control word and reconfiguration status word of the remote update circuit.
// Assumes: Clocked by the internal oscillator or user startup clock; inputs synchronous.
// Notes: Shift/update protocol, watchdog counter and reconfiguration sequencer are outside.
//
// Functional notes
// [RULE1] Serial flash scheme: boot address zero at power-up.
// [RULE2] Parallel flash scheme: boot address 010000 at power-up.
// [RULE3] JTAG instruction replaces parallel factory boot address.
// [RULE4] Only factory image may write control contents.
// [RULE5] Control word fixed 39-bit field layout.
// [RULE6] Watchdog count is timeout bits plus pattern.
// [RULE7] Boot address is page bits plus two zeros.
// [RULE8] Early done check verifies image, else factory reload.
// [RULE9] Oscillator select clocks startup from internal oscillator.
// [RULE10] Factory image sets early check and oscillator bits.
// [RULE11] Status records which trigger caused reconfiguration.
// [RULE12] Factory status view: state, zeros, boot address.
// [RULE13] Application view one: state, enable, watchdog count.
// [RULE14] Application view two: state, zeros, boot address.
// [RULE15] Status is 32 bits, layout by master state.
// [RULE16] Reconfiguration start copies update into control. Code copies only on a fabric trigger; error causes clear control instead.
// [RULE17] Status rewritten on every reconfiguration.
// [RULE18] Registers run on startup clock, not shift clock.
// [RULE19] Application image cannot write update register.
// [RULE20] Reserved bits stored, returned, otherwise ignored.
`timescale 1ns/1ps
`default_nettype none

module rsu_regs (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Configuration scheme and JTAG factory address override.
  input wire logic i_parallel_flash_scheme,
  input wire logic i_factory_addr_load,
  input wire logic [23:0] i_factory_addr,
  // Update register write path from the shift register.
  input wire logic i_update_write,
  input wire logic [38:0] i_update_data,
  // Reconfiguration events.
  input wire logic i_reconfig_start,
  input wire rsu_pkg::rsu_cause_t i_cause,
  input wire logic i_enter_app,
  // Early done check inputs.
  input wire logic i_image_size_ok,
  input wire logic i_done_too_early,
  // Status view select.
  input wire logic [1:0] i_status_view,
  // Register contents.
  output logic [38:0] o_control_word,
  output logic [38:0] o_update_word,
  output logic [31:0] o_status_word,
  output rsu_pkg::rsu_cause_t o_cause,
  // Derived values and startup controls.
  output logic [23:0] o_boot_address,
  output logic [28:0] o_wdog_count,
  output logic o_wdog_enable,
  output logic o_startup_osc_select,
  output logic o_app_mode,
  output logic o_factory_reload,
  output logic o_update_write_blocked
);

  // Builds the 24-bit boot address from the stored page bits.
  function automatic logic [23:0] boot_of(input logic [38:0] w);
    boot_of = {w[rsu_pkg::CTL_PAGE_MSB:rsu_pkg::CTL_PAGE_LSB], rsu_pkg::BOOT_PAD}; // [RULE7]
  endfunction : boot_of

  // Builds the 29-bit watchdog count from the stored timeout bits.
  function automatic logic [28:0] wdcnt_of(input logic [38:0] w);
    wdcnt_of = {w[rsu_pkg::CTL_WDT_MSB:rsu_pkg::CTL_WDT_LSB], rsu_pkg::WD_PAD}; // [RULE6]
  endfunction : wdcnt_of

  // Packs a power-up control word around a given boot address.
  function automatic logic [38:0] reset_word(input logic [23:0] addr);
    rsu_pkg::rsu_ctl_t c;
    c.reserved_high_bit = rsu_pkg::RST_RSV_HI;
    c.early_done_check = rsu_pkg::RST_EARLY;
    c.osc_select = rsu_pkg::RST_OSC;
    c.wdog_enable = rsu_pkg::RST_WDEN;
    c.reserved_low_bit = rsu_pkg::RST_RSV_LO;
    c.boot_page_address = addr[23:2]; // [RULE5]
    c.wdog_timeout_msb = rsu_pkg::RST_WDT;
    reset_word = c;
  endfunction : reset_word

  typedef enum logic {ST_FACTORY, ST_APP} rsu_master_t;

  rsu_master_t master;
  rsu_master_t next_master;
  logic [38:0] control;
  logic [38:0] next_control;
  logic [38:0] update;
  logic [38:0] next_update;
  logic [23:0] factory_addr;
  logic [23:0] next_factory_addr;
  logic [31:0] status;
  logic [31:0] next_status;
  rsu_pkg::rsu_cause_t cause;
  rsu_pkg::rsu_cause_t next_cause;
  logic powered;
  logic next_powered;
  logic reload;
  logic next_reload;
  logic [1:0] state_code;
  logic error_cause;
  logic early_fail;

  // State code and error classification.
  assign state_code = (master == ST_APP) ? rsu_pkg::MS_APP : rsu_pkg::MS_FACTORY;
  assign error_cause = i_cause.cfg_reset | i_cause.crc_error | i_cause.status_line
                       | i_cause.wdog_timeout;
  // An early done failure only counts while the check bit is set.
  assign early_fail = control[rsu_pkg::CTL_EARLY_BIT]
                      & (~i_image_size_ok | i_done_too_early); // [RULE8]

  // Next-state logic for control, update, master state and cause.
  always_comb
  begin
    next_master = master;
    next_control = control;
    next_update = update;
    next_factory_addr = factory_addr;
    next_cause = cause;
    next_powered = 1'b1;
    next_reload = 1'b0;
    // Strap the power-up boot address on the first edge after reset.
    if (!powered)
    begin
      next_control = reset_word(i_parallel_flash_scheme ? factory_addr
                                : rsu_pkg::BOOT_SERIAL_RST); // [RULE1] [RULE2]
    end
    // JTAG override of the parallel factory boot address.
    if (i_factory_addr_load && i_parallel_flash_scheme)
    begin
      next_factory_addr = i_factory_addr; // [RULE3]
    end
    // The factory register resets with the block, so while the factory image runs the override also moves the running boot page.
    if (i_factory_addr_load && i_parallel_flash_scheme && powered && master == ST_FACTORY)
    begin
      next_control[rsu_pkg::CTL_PAGE_MSB:rsu_pkg::CTL_PAGE_LSB] = i_factory_addr[23:2]; // [RULE3]
    end
    // Update writes only while the factory image runs.
    if (i_update_write && master == ST_FACTORY)
    begin
      next_update = i_update_data; // [RULE4] [RULE19]
    end
    if (i_reconfig_start && powered)
    begin
      next_cause = i_cause; // [RULE11] [RULE17]
      if (error_cause)
      begin
        next_control = '0;
        next_master = ST_FACTORY;
      end
      else if (i_cause.fabric_trigger)
      begin
        next_control = update; // [RULE16] [RULE20]
        next_master = ST_FACTORY;
      end
    end
    else if (i_enter_app && powered && master == ST_FACTORY)
    begin
      if (early_fail)
      begin
        next_control = '0; // [RULE8]
        next_reload = 1'b1;
      end
      else
      begin
        next_master = ST_APP;
      end
    end
  end

  // Registers for control, update and master state.
  always_ff @(posedge i_clk or posedge i_reset) // [RULE18]
  begin
    if (i_reset)
    begin
      master <= ST_FACTORY;
      control <= '0;
      update <= '0;
      factory_addr <= rsu_pkg::BOOT_PARALLEL_RST;
      cause <= '0;
      powered <= 1'b0;
      reload <= 1'b0;
    end
    else
    begin
      master <= next_master;
      control <= next_control;
      update <= next_update;
      factory_addr <= next_factory_addr;
      cause <= next_cause;
      powered <= next_powered;
      reload <= next_reload;
    end
  end

  // Status word formatting by view and master state.
  always_comb
  begin
    next_status = {state_code, rsu_pkg::ST_PAD, boot_of(control)}; // [RULE12]
    if (master == ST_APP)
    begin
      case (i_status_view)
        rsu_pkg::VIEW_APP1:
          next_status = {state_code, control[rsu_pkg::CTL_WDEN_BIT],
                         wdcnt_of(control)}; // [RULE13]
        rsu_pkg::VIEW_APP2:
          next_status = {state_code, rsu_pkg::ST_PAD, boot_of(control)}; // [RULE14]
        default:
          next_status = {state_code, rsu_pkg::ST_PAD, boot_of(control)}; // [RULE15]
      endcase
    end
  end

  // Status register.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      status <= '0;
    end
    else
    begin
      status <= next_status;
    end
  end

  // Outputs.
  assign o_control_word = control;
  assign o_update_word = update;
  assign o_status_word = status;
  assign o_cause = cause;
  assign o_boot_address = boot_of(control);
  assign o_wdog_count = wdcnt_of(control);
  assign o_wdog_enable = control[rsu_pkg::CTL_WDEN_BIT];
  assign o_startup_osc_select = control[rsu_pkg::CTL_OSC_BIT]; // [RULE9]
  assign o_app_mode = (master == ST_APP);
  assign o_factory_reload = reload;
  assign o_update_write_blocked = i_update_write & (master == ST_APP); // [RULE19]

endmodule : rsu_regs

`default_nettype wire

// *** common/rsu_pkg.sv ***
// Purpose: Shared constants and types for the boot control and reconfiguration status block.
// Assumes: One clock domain (startup clock), asynchronous active-high reset.
// Notes: Control word is 39 bits, status word is 32 bits.
package rsu_pkg;

  // Control word field positions.
  localparam int CTL_W = 39;
  localparam int CTL_RSV_HI_BIT = 38;
  localparam int CTL_EARLY_BIT = 37;
  localparam int CTL_OSC_BIT = 36;
  localparam int CTL_WDEN_BIT = 35;
  localparam int CTL_RSV_LO_BIT = 34;
  localparam int CTL_PAGE_MSB = 33;
  localparam int CTL_PAGE_LSB = 12;
  localparam int CTL_WDT_MSB = 11;
  localparam int CTL_WDT_LSB = 0;

  // Derived value widths and fixed padding.
  localparam int PAGE_W = 22;
  localparam int WDT_W = 12;
  localparam int BOOT_W = 24;
  localparam int WDCNT_W = 29;
  localparam logic [16:0] WD_PAD = 17'h00008;
  localparam logic [1:0] BOOT_PAD = 2'h0;

  // Power-up boot addresses per flash scheme.
  localparam logic [23:0] BOOT_SERIAL_RST = 24'h000000;
  localparam logic [23:0] BOOT_PARALLEL_RST = 24'h010000;

  // Power-up option and reserved bit values.
  localparam logic RST_WDEN = 1'h1;
  localparam logic RST_OSC = 1'h1;
  localparam logic RST_EARLY = 1'h1;
  localparam logic RST_RSV_HI = 1'h1;
  localparam logic RST_RSV_LO = 1'h0;
  localparam logic [11:0] RST_WDT = 12'h000;

  // Status word field positions.
  localparam int ST_W = 32;
  localparam int ST_STATE_MSB = 31;
  localparam int ST_STATE_LSB = 30;
  localparam int ST_WDEN_BIT = 29;
  localparam logic [5:0] ST_PAD = 6'h00;

  // Master state encoding reported in status bits 31:30.
  localparam logic [1:0] MS_FACTORY = 2'h0;
  localparam logic [1:0] MS_APP = 2'h1;

  // Status view select.
  localparam logic [1:0] VIEW_FACTORY = 2'h0;
  localparam logic [1:0] VIEW_APP1 = 2'h1;
  localparam logic [1:0] VIEW_APP2 = 2'h2;

  // Reconfiguration cause vector.
  typedef struct packed {
    logic cfg_reset;
    logic crc_error;
    logic status_line;
    logic wdog_timeout;
    logic fabric_trigger;
  } rsu_cause_t;

  // Control word fields.
  typedef struct packed {
    logic reserved_high_bit;
    logic early_done_check;
    logic osc_select;
    logic wdog_enable;
    logic reserved_low_bit;
    logic [21:0] boot_page_address;
    logic [11:0] wdog_timeout_msb;
  } rsu_ctl_t;

endpackage : rsu_pkg

// *** testbench/rsu_fab_model.sv ***
// Purpose: Factory-image fabric logic that writes the update word and starts a reconfiguration.
// Assumes: Runs on the same startup clock as the register block.
// Notes: Data lines toggle once released so a stale word is never mistaken for a fresh one.
`timescale 1ns/1ps
`default_nettype none
module rsu_fab_model (
  // Clock, reset and command.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_go,
  input wire logic [38:0] i_word,
  // Towards the register block.
  output logic o_wr,
  output logic [38:0] o_data,
  output logic o_trig
);
  // One update write, then a fabric trigger on the following cycle.
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_wr <= 1'b0;
      o_trig <= 1'b0;
      o_data <= 39'h0;
    end
    else
    begin
      o_wr <= i_go;
      o_trig <= o_wr;
      o_data <= i_go ? (i_word | 39'h3000000000) : ~o_data;
    end
  end
endmodule : rsu_fab_model
`default_nettype wire

// *** testbench/rsu_regs_props.sv ***
// Purpose: Port-level checks of the boot control and status register block.
// Assumes: Single startup clock, asynchronous active-high reset.
// Notes: Status relations skip the first edge after reset, when the status is still empty.
`timescale 1ns/1ps
`default_nettype none
module rsu_regs_chk (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Requests.
  input wire logic i_update_write,
  input wire logic i_reconfig_start,
  input wire rsu_pkg::rsu_cause_t i_cause,
  input wire logic [1:0] i_status_view,
  // Results.
  input wire logic [38:0] o_control_word,
  input wire logic [38:0] o_update_word,
  input wire logic [31:0] o_status_word,
  input wire rsu_pkg::rsu_cause_t o_cause,
  input wire logic [23:0] o_boot_address,
  input wire logic [28:0] o_wdog_count,
  input wire logic o_wdog_enable,
  input wire logic o_startup_osc_select,
  input wire logic o_app_mode,
  input wire logic o_factory_reload,
  input wire logic o_update_write_blocked
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Derived values follow the stored control fields.
  a_boot_addr_form: assert property (o_boot_address == {o_control_word[33:12], 2'h0})
    else $error("boot address not page bits plus two zeros");
  a_wdog_count_form: assert property (o_wdog_count == {o_control_word[11:0], 17'h00008})
    else $error("watchdog count not timeout bits plus pattern");
  a_option_bit_map: assert property (o_wdog_enable == o_control_word[35]
    && o_startup_osc_select == o_control_word[36]) else $error("option bits misplaced");
  // Writes from an application image are refused and leave the update word alone.
  a_write_refused: assert property (o_update_write_blocked == (i_update_write && o_app_mode))
    else $error("refusal flag wrong");
  a_update_kept: assert property (i_update_write && o_app_mode |=> $stable(o_update_word))
    else $error("update word changed in application mode");
  // Reconfiguration effects on the control word and cause.
  a_fabric_copy: assert property (i_reconfig_start && i_cause == 5'h01
    |=> o_control_word == $past(o_update_word)) else $error("update not copied");
  a_error_clear: assert property (i_reconfig_start && i_cause[4:1] != 4'h0
    |=> o_control_word == 39'h0 && !o_app_mode) else $error("error did not clear control");
  a_cause_record: assert property (i_reconfig_start |=> o_cause == $past(i_cause))
    else $error("cause not recorded");
  a_reload_fact: assert property (o_factory_reload |-> o_control_word == 39'h0 ##1 !o_factory_reload)
    else $error("reload without factory control");
  // Status formats one cycle behind the state they report.
  a_status_fact: assert property (!$past(i_reset) && !$past(o_app_mode)
    |-> o_status_word == {8'h00, $past(o_boot_address)}) else $error("factory status wrong");
  a_status_app1: assert property (!$past(i_reset) && $past(o_app_mode)
    && $past(i_status_view) == 2'h1
    |-> o_status_word == {2'h1, $past(o_wdog_enable), $past(o_wdog_count)})
    else $error("application status one wrong");
  a_status_app2: assert property (!$past(i_reset) && $past(o_app_mode)
    && $past(i_status_view) == 2'h2
    |-> o_status_word == {2'h1, 6'h00, $past(o_boot_address)})
    else $error("application status two wrong");
  c_fabric: cover property (i_reconfig_start && i_cause == 5'h01);
  c_reload: cover property (o_factory_reload);
  c_refused: cover property (o_update_write_blocked);
endmodule : rsu_regs_chk
bind rsu_regs rsu_regs_chk u_rsu_regs_chk (.i_clk(i_clk), .i_reset(i_reset),
  .i_update_write(i_update_write), .i_reconfig_start(i_reconfig_start), .i_cause(i_cause),
  .i_status_view(i_status_view), .o_control_word(o_control_word), .o_update_word(o_update_word),
  .o_status_word(o_status_word), .o_cause(o_cause), .o_boot_address(o_boot_address),
  .o_wdog_count(o_wdog_count), .o_wdog_enable(o_wdog_enable),
  .o_startup_osc_select(o_startup_osc_select), .o_app_mode(o_app_mode),
  .o_factory_reload(o_factory_reload), .o_update_write_blocked(o_update_write_blocked));
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the boot control and status register block.
// Assumes: Fixed answer latencies of the register block; 5 ns startup clock.
// Notes: Expected results go into a queue; a negedge monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed { logic [1:0] kind; logic [38:0] val; } rsu_note_t;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic scheme = 1'b0, go = 1'b0, rs = 1'b0, enter = 1'b0, size_ok = 1'b1, early = 1'b0;
  logic wr, trig;
  logic jl = 1'b0;
  logic [1:0] view = 2'h0;
  logic [38:0] word = 39'h0, w, up_d, cw, uw;
  logic [31:0] sw;
  rsu_pkg::rsu_cause_t cause = 5'h00, oc;
  int err_count = 0, num_checks = 0, seed = 32'h2b13a2cc;
  rsu_note_t exp_q[$], n;
  // Free-running startup clock.
  always #2.5 i_clk = ~i_clk;
  rsu_fab_model u_rsu_fab_model (.i_clk(i_clk), .i_reset(i_reset), .i_go(go), .i_word(word),
    .o_wr(wr), .o_data(up_d), .o_trig(trig));
  rsu_regs u_rsu_regs (.i_clk(i_clk), .i_reset(i_reset), .i_parallel_flash_scheme(scheme),
    .i_factory_addr_load(jl), .i_factory_addr(24'h123454), .i_update_write(wr),
    .i_update_data(up_d), .i_reconfig_start(rs | trig),
    .i_cause(rsu_pkg::rsu_cause_t'(cause | {4'h0, trig})), .i_enter_app(enter),
    .i_image_size_ok(size_ok), .i_done_too_early(early), .i_status_view(view),
    .o_control_word(cw), .o_update_word(uw), .o_status_word(sw), .o_cause(oc),
    .o_boot_address(), .o_wdog_count(), .o_wdog_enable(), .o_startup_osc_select(),
    .o_app_mode(), .o_factory_reload(), .o_update_write_blocked());
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [38:0] got, input logic [38:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask : tick
  task automatic check(input logic [1:0] k, input logic [38:0] v);
    exp_q.push_back('{k, v});
    tick(1);
  endtask : check
  task automatic reset_dut(input logic par);
    i_reset <= 1'b1;
    scheme <= par;
    tick(2);
    i_reset <= 1'b0;
    tick(2);
  endtask : reset_dut
  task automatic load(input logic [38:0] v);
    word <= v;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(3);
  endtask : load
  task automatic reconf(input rsu_pkg::rsu_cause_t c);
    cause <= c;
    rs <= 1'b1;
    tick(1);
    rs <= 1'b0;
    cause <= 5'h00;
  endtask : reconf
  task automatic enter_app(input logic ok, input logic too_early);
    size_ok <= ok;
    early <= too_early;
    enter <= 1'b1;
    tick(1);
    enter <= 1'b0;
    tick(1);
  endtask : enter_app
  // Takes the oldest note once the outputs have settled and compares it.
  always @(negedge i_clk)
    if (exp_q.size() > 0)
    begin
      n = exp_q.pop_front();
      cmp(n.kind == 2'h0 ? cw : n.kind == 2'h1 ? {7'h0, sw} : n.kind == 2'h2 ? uw : {34'h0, oc},
        n.val);
    end
  // Main sequence.
  initial
  begin
    reset_dut(1'b0);
    check(2'h0, 39'h7800000000);
    check(2'h1, 39'h0);
    w = 39'({$random(seed), $random(seed)});
    load(w);
    w = w | 39'h3000000000;
    check(2'h2, w);
    check(2'h0, w);
    check(2'h1, {15'h0, w[33:12], 2'h0});
    view <= 2'h1;
    enter_app(1'b1, 1'b0);
    check(2'h1, {7'h0, 2'h1, w[35], w[11:0], 17'h00008});
    view <= 2'h2;
    tick(1);
    check(2'h1, {7'h0, 2'h1, 6'h0, w[33:12], 2'h0});
    load(~w);
    check(2'h2, w);
    for (int i = 1; i < 5; i++)
    begin
      load(w);
      reconf(rsu_pkg::rsu_cause_t'(5'h01 << i));
      check(2'h0, 39'h0);
      check(2'h3, 39'(5'h01 << i));
    end
    for (int i = 0; i < 2; i++)
    begin
      load(w);
      enter_app(i[0], i[0]);
      check(2'h0, 39'h0);
    end
    reset_dut(1'b1);
    check(2'h0, 39'h7804000000);
    check(2'h1, 39'h0000010000);
    // Factory boot address override while the parallel scheme runs the factory image.
    jl <= 1'b1;
    tick(1);
    jl <= 1'b0;
    check(2'h0, 39'h7848d15000);
    check(2'h1, 39'h0000123454);
    end_of_test();
  end
  // Cuts a hung run short.
  initial
  begin
    #50000;
    err_count++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
